// ==== hdl/urti_core.sv ====
// Flow request, buffer interrupt thresholds and receive idle timeout with AHB-Lite registers
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "urti_params.svh"
module urti_core import urti_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive and transmit buffer side
  input wire logic rx_byte_done,
  input wire logic [3:0] rx_buf_cnt,
  input wire logic [3:0] tx_buf_cnt,
  // Link and DMA side
  output logic rts,
  output logic rx_dma_done,
  output logic [3:0] bit_cycles,
  output logic rx_dma_en,
  // Interrupt
  output logic irq
);

  urti_core_t s_r;
  urti_core_t s_nxt;
  logic take;
  logic [7:0] a_idx;
  logic [2:0] ev;
  logic [2:0] clr;

  urti_if ifc ();

  urti_timeout u_tmo (
    .mclk(mclk),
    .rst(rst),
    .bus(ifc.tmo)
  );

  urti_level u_lvl (
    .mclk(mclk),
    .rst(rst),
    .bus(ifc.lvl)
  );

  assign ifc.byte_done = rx_byte_done;
  assign ifc.dma_en = s_r.ctrl[`URTI_CTRL_RXDMA];
  assign ifc.tbase = s_r.tbase;
  assign ifc.tscale = s_r.tscale;
  assign ifc.rx_cnt = rx_buf_cnt;
  assign ifc.tx_cnt = tx_buf_cnt;
  assign ifc.flow = s_r.flow;
  assign ifc.thr = s_r.thr;

  // Read value of a register index; unmapped and write-only read as zero
  function automatic logic [31:0] rd_word(input urti_core_t s, input logic [7:0] idx);
    rd_word = 32'h0000_0000;
    if (idx == `URTI_IDX_CTRL) begin
      rd_word = {24'h000000, s.ctrl};
    end else if (idx == `URTI_IDX_FLOW) begin
      rd_word = {24'h000000, s.flow};
    end else if (idx == `URTI_IDX_THR) begin
      rd_word = {24'h000000, s.thr};
    end else if (idx == `URTI_IDX_TBASE) begin
      rd_word = {24'h000000, s.tbase};
    end else if (idx == `URTI_IDX_TSCALE) begin
      rd_word = {30'h0000_0000, s.tscale};
    end else if (idx == `URTI_IDX_ISTAT) begin
      rd_word = {29'h0000_0000, s.istat};
    end else if (idx == `URTI_IDX_IEN) begin
      rd_word = {29'h0000_0000, s.ien};
    end
  endfunction

  always_comb begin
    take = hsel && hready && htrans[1];
    a_idx = haddr[9:2];
    s_nxt = s_r;
    clr = 3'h0;
    // Data phase write; zero wait states so hwdata stands in this cycle
    if (s_r.ph_wr) begin
      if (s_r.ph_idx == `URTI_IDX_CTRL) begin
        s_nxt.ctrl = hwdata[7:0];
      end else if (s_r.ph_idx == `URTI_IDX_FLOW) begin
        s_nxt.flow = hwdata[7:0];
      end else if (s_r.ph_idx == `URTI_IDX_THR) begin
        s_nxt.thr = hwdata[7:0];
      end else if (s_r.ph_idx == `URTI_IDX_TBASE) begin
        s_nxt.tbase = hwdata[7:0];
      end else if (s_r.ph_idx == `URTI_IDX_TSCALE) begin
        s_nxt.tscale = hwdata[1:0];
      end else if (s_r.ph_idx == `URTI_IDX_ICLR) begin
        clr = hwdata[2:0];
      end else if (s_r.ph_idx == `URTI_IDX_IEN) begin
        s_nxt.ien = hwdata[2:0];
      end
    end
    // Address phase; read data sampled now, so it predates a write in this same cycle
    s_nxt.ph_wr = take && hwrite;
    s_nxt.ph_idx = a_idx;
    if (take && !hwrite) begin
      s_nxt.rdata = rd_word(s_r, a_idx);
    end
    // Buffer events on the rising edge of each threshold condition
    s_nxt.hit_q = {ifc.tx_hit, ifc.rx_hit};
    ev[`URTI_IRQ_RXBUF] = ifc.rx_hit && !s_r.hit_q[0];
    ev[`URTI_IRQ_TXBUF] = ifc.tx_hit && !s_r.hit_q[1];
    ev[`URTI_IRQ_TMO] = ifc.expired;
    // Set wins over a clear in the same cycle
    s_nxt.istat = (s_r.istat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.istat & s_nxt.ien);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.ctrl <= `URTI_RST_CTRL;
      s_r.flow <= `URTI_RST_FLOW;
      s_r.thr <= `URTI_RST_THR;
      s_r.tbase <= `URTI_RST_TBASE;
      s_r.tscale <= `URTI_RST_TSCALE;
      s_r.istat <= 3'h0;
      s_r.ien <= 3'h0;
      s_r.hit_q <= 2'h0;
      s_r.ph_wr <= 1'b0;
      s_r.ph_idx <= 8'h00;
      s_r.rdata <= 32'h0000_0000;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Slave never stalls and always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign rts = ifc.rts;
  assign rx_dma_done = ifc.expired;
  // Values below the legal minimum are passed as written; software keeps it above 2
  assign bit_cycles = s_r.ctrl[`URTI_CTRL_BWPC];
  assign rx_dma_en = s_r.ctrl[`URTI_CTRL_RXDMA];
  assign irq = s_r.irq;

endmodule

// ==== hdl/urti_params.svh ====
// Register map, field positions, reset values and timing for the receive flow and timeout block
`ifndef URTI_PARAMS_SVH
`define URTI_PARAMS_SVH

// Register indices; byte address is four times the index
`define URTI_IDX_CTRL 8'h96
`define URTI_IDX_FLOW 8'h98
`define URTI_IDX_THR 8'h99
`define URTI_IDX_TBASE 8'h9A
`define URTI_IDX_TSCALE 8'h9B
`define URTI_IDX_ISTAT 8'hA0
`define URTI_IDX_ICLR 8'hA1
`define URTI_IDX_IEN 8'hA2

// Reset values
`define URTI_RST_CTRL 8'h0F
`define URTI_RST_FLOW 8'hA5
`define URTI_RST_THR 8'h44
`define URTI_RST_TBASE 8'hC0
`define URTI_RST_TSCALE 2'h0

// Control register fields
`define URTI_CTRL_BWPC 3:0
`define URTI_CTRL_RXDMA 4

// Flow request control fields
`define URTI_FLOW_TRIG 3:0
`define URTI_FLOW_POL 4
`define URTI_FLOW_MVAL 5
`define URTI_FLOW_MEN 6
`define URTI_FLOW_EN 7

// Threshold fields
`define URTI_THR_RX 3:0
`define URTI_THR_TX 7:4

// Interrupt bits
`define URTI_IRQ_RXBUF 0
`define URTI_IRQ_TXBUF 1
`define URTI_IRQ_TMO 2
`define URTI_NIRQ 3

// Least legal per-bit cycle count
`define URTI_BWPC_MIN 4'h3

`endif

// ==== hdl/urti_pkg.sv ====
// Types and shared helpers for the receive flow and timeout block
package urti_pkg;

  typedef enum logic [1:0] {
    URTI_TMO_IDLE = 2'b01,
    URTI_TMO_RUN = 2'b10
  } urti_tmo_state_t;

  typedef struct packed {
    urti_tmo_state_t st;
    logic [9:0] cnt;
    logic expired;
  } urti_tmo_t;

  typedef struct packed {
    logic rts;
    logic rx_hit;
    logic tx_hit;
  } urti_lvl_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] flow;
    logic [7:0] thr;
    logic [7:0] tbase;
    logic [1:0] tscale;
    logic [2:0] istat;
    logic [2:0] ien;
    logic [1:0] hit_q;
    logic ph_wr;
    logic [7:0] ph_idx;
    logic [31:0] rdata;
    logic irq;
  } urti_core_t;

  // Fill level reached
  function automatic logic urti_reached(input logic [3:0] cnt, input logic [3:0] trig);
    urti_reached = (cnt >= trig);
  endfunction

endpackage

// ==== hdl/urti_if.sv ====
// Signals shared between the register core, the timeout counter and the level logic
`timescale 1ns/10ps
interface urti_if;
  logic byte_done;
  logic dma_en;
  logic [7:0] tbase;
  logic [1:0] tscale;
  logic expired;
  logic [3:0] rx_cnt;
  logic [3:0] tx_cnt;
  logic [7:0] flow;
  logic [7:0] thr;
  logic rts;
  logic rx_hit;
  logic tx_hit;

  modport core (output byte_done, dma_en, tbase, tscale, rx_cnt, tx_cnt, flow, thr,
    input expired, rts, rx_hit, tx_hit);
  modport tmo (input byte_done, dma_en, tbase, tscale, output expired);
  modport lvl (input rx_cnt, tx_cnt, flow, thr, output rts, rx_hit, tx_hit);
endinterface

// ==== hdl/urti_timeout.sv ====
// Receive idle timeout counter
`timescale 1ns/10ps
`include "urti_params.svh"
module urti_timeout import urti_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core side
  urti_if.tmo bus
);

  urti_tmo_t s_r;
  urti_tmo_t s_nxt;
  logic [9:0] limit;

  always_comb begin
    limit = 10'(bus.tbase) * (10'(bus.tscale) + 10'h001);
    s_nxt = s_r;
    s_nxt.expired = 1'b0;
    case (s_r.st)
      URTI_TMO_IDLE: begin
        s_nxt.cnt = 10'h000;
      end
      URTI_TMO_RUN: begin
        if (!bus.dma_en) begin
          s_nxt.st = URTI_TMO_IDLE;
        end else if (s_r.cnt + 10'h001 >= limit) begin
          s_nxt.expired = 1'b1;
          s_nxt.st = URTI_TMO_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + 10'h001;
        end
      end
      default: begin
        s_nxt.st = URTI_TMO_IDLE;
      end
    endcase
    // New byte restarts the idle wait
    if (bus.byte_done && bus.dma_en) begin
      s_nxt.st = URTI_TMO_RUN;
      // A byte in the expiry cycle means the burst has not ended
      s_nxt.expired = 1'b0;
      s_nxt.cnt = 10'h000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{st: URTI_TMO_IDLE, cnt: 10'h000, expired: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.expired = s_r.expired;

endmodule

// ==== hdl/urti_level.sv ====
// Flow request line and buffer threshold comparison
`timescale 1ns/10ps
`include "urti_params.svh"
module urti_level import urti_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core side
  urti_if.lvl bus
);

  urti_lvl_t s_r;
  urti_lvl_t s_nxt;
  logic stop_req;

  always_comb begin
    stop_req = urti_reached(bus.rx_cnt, bus.flow[`URTI_FLOW_TRIG]);
    s_nxt = s_r;
    if (!bus.flow[`URTI_FLOW_EN]) begin
      s_nxt.rts = bus.flow[`URTI_FLOW_POL];
    end else if (bus.flow[`URTI_FLOW_MEN]) begin
      s_nxt.rts = bus.flow[`URTI_FLOW_MVAL];
    end else begin
      s_nxt.rts = stop_req ^ bus.flow[`URTI_FLOW_POL];
    end
    s_nxt.rx_hit = urti_reached(bus.rx_cnt, bus.thr[`URTI_THR_RX]);
    s_nxt.tx_hit = (bus.tx_cnt <= bus.thr[`URTI_THR_TX]);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{rts: 1'b1, rx_hit: 1'b0, tx_hit: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rts = s_r.rts;
  assign bus.rx_hit = s_r.rx_hit;
  assign bus.tx_hit = s_r.tx_hit;

endmodule

// ==== verification/urti_checker.sv ====
// Assertion checker for the flow request and receive timeout block
`timescale 1ns/10ps
`include "urti_params.svh"
module urti_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Link and status
  input wire logic rx_byte_done,
  input wire logic [3:0] rx_buf_cnt,
  input wire logic rts,
  input wire logic rx_dma_done,
  input wire logic [3:0] bit_cycles,
  input wire logic rx_dma_en,
  input wire logic irq
);
  logic wph_r;
  logic [7:0] wix_r;
  logic [7:0] flow_r;
  logic [4:0] ctrl_r;
  logic [7:0] tb_r;
  logic [1:0] ts_r;
  logic arm_r;
  logic [10:0] cnt_r;
  logic [10:0] lim;
  logic rts_exp;
  // Zero base behaves as one cycle
  assign lim = (tb_r == 8'h00) ? 11'h001 : 11'(tb_r) * (11'(ts_r) + 11'h001);
  assign rts_exp = !flow_r[7] ? flow_r[4] : flow_r[6] ? flow_r[5] : (rx_buf_cnt >= flow_r[3:0]) ^ flow_r[4];
  // Shadow of the written flow, control, timeout base and timeout scale registers
  always_ff @(posedge mclk) begin
    wph_r <= hsel && hready && htrans[1] && hwrite && !rst;
    wix_r <= haddr[9:2];
    if (rst) begin
      flow_r <= `URTI_RST_FLOW;
      ctrl_r <= 5'h0F;
      tb_r <= `URTI_RST_TBASE;
      ts_r <= `URTI_RST_TSCALE;
    end else if (wph_r) begin
      if (wix_r == `URTI_IDX_FLOW) flow_r <= hwdata[7:0];
      if (wix_r == `URTI_IDX_CTRL) ctrl_r <= hwdata[4:0];
      if (wix_r == `URTI_IDX_TBASE) tb_r <= hwdata[7:0];
      if (wix_r == `URTI_IDX_TSCALE) ts_r <= hwdata[1:0];
    end
  end
  // Cycles since the last byte taken
  always_ff @(posedge mclk) begin
    if (rst || !ctrl_r[4]) begin
      arm_r <= 1'b0;
      cnt_r <= 11'h000;
    end else if (rx_byte_done) begin
      arm_r <= 1'b1;
      cnt_r <= 11'h000;
    end else if (arm_r) begin
      cnt_r <= cnt_r + 11'h001;
      arm_r <= cnt_r != lim;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rts_level_a: assert property (!$past(rst) |-> rts == $past(rts_exp))
    else $error("flow request level wrong");
  dma_time_a: assert property (rx_dma_done == (arm_r && cnt_r == lim))
    else $error("timeout pulse at wrong cycle");
  dma_once_a: assert property (rx_dma_done |=> !rx_dma_done)
    else $error("timeout pulse too long");
  dma_gate_a: assert property (rx_dma_done |-> $past(ctrl_r[4]))
    else $error("timeout without receive dma");
  byte_restart_a: assert property (rx_byte_done && ctrl_r[4] |=> !rx_dma_done)
    else $error("timeout right after a byte");
  cfg_out_a: assert property ({rx_dma_en, bit_cycles} == ctrl_r)
    else $error("control outputs differ from control");
  irq_fall_a: assert property ($fell(irq) |-> $past(wph_r))
    else $error("interrupt fell without a write");
  rdata_hi_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  cover property (rx_dma_done);
  cover property ($rose(irq));
  cover property (rts && flow_r[6]);
endmodule

// ==== verification/urti_remote.sv ====
// Remote sender model that fills the receive buffer byte by byte
`timescale 1ns/10ps
module urti_remote (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Flow request
  input wire logic rts,
  // Bench commands
  input wire logic go,
  input wire logic clr,
  input wire logic [3:0] nb,
  // Receive side
  output logic rx_byte_done,
  output logic [3:0] rx_buf_cnt
);
  // Short inter-byte gap, well below any timeout used
  localparam logic [4:0] GAP = 5'h14;
  logic [3:0] left;
  logic [4:0] t;
  always_ff @(posedge mclk) begin
    rx_byte_done <= 1'b0;
    if (rst) begin
      left <= 4'h0;
      t <= 5'h00;
    end else if (go) begin
      left <= nb;
      t <= 5'h00;
    end else if (left != 4'h0 && !rts) begin
      t <= t + 5'h01;
      if (t == GAP) begin
        t <= 5'h00;
        left <= left - 4'h1;
        rx_byte_done <= 1'b1;
        rx_buf_cnt <= rx_buf_cnt + 4'h1;
      end
    end
    if (rst || clr) rx_buf_cnt <= 4'h0;
  end
endmodule

// ==== verification/urti_core_tb_top.sv ====
// Testbench for the flow request and receive timeout block
`timescale 1ns/10ps
`include "urti_params.svh"
bind urti_core urti_checker u_chk (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .rx_byte_done, .rx_buf_cnt, .rts, .rx_dma_done, .bit_cycles, .rx_dma_en, .irq);
module urti_core_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] tx_buf_cnt = 4'hF;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic [3:0] nb = 4'h0;
  logic rdph = 1'b0;
  logic hreadyout, hresp, rts, rx_dma_done, rx_dma_en, irq, rx_byte_done;
  logic [31:0] hrdata;
  logic [3:0] bit_cycles, rx_buf_cnt;
  logic [10:0] since = 11'h000;
  logic [31:0] rq[$];
  logic [10:0] tq[$];
  int errors = 0;
  int compares = 0;
  always #10 mclk = ~mclk;
  urti_core u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .rx_byte_done, .rx_buf_cnt, .tx_buf_cnt, .rts, .rx_dma_done, .bit_cycles,
    .rx_dma_en, .irq);
  urti_remote u_rem (.mclk, .rst, .rts, .go, .clr, .nb, .rx_byte_done, .rx_buf_cnt);
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask
  // Reads take d as the expected word
  task automatic xf(input logic w, input logic [7:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdph <= !w;
    if (!w) rq.push_back(d);
    rdy();
    rdph <= 1'b0;
  endtask
  // Third edge reads the values launched at the second, before its own updates
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic send(input logic [3:0] n);
    clr <= 1'b1;
    nb <= n;
    go <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    go <= 1'b0;
  endtask
  task automatic wcnt(input logic [3:0] e);
    int n;
    n = 0;
    while (rx_buf_cnt !== e && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk({28'h0, rx_buf_cnt}, {28'h0, e});
    if (n >= 400) stop_test();
  endtask
  task automatic wdone;
    int n;
    n = 0;
    while (tq.size() != 0 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    if (tq.size() != 0) begin
      errors++;
      stop_test();
    end
  endtask
  always @(posedge mclk) begin
    since <= rx_byte_done ? 11'h000 : since + 11'h001;
    if (rdph && hreadyout) chk(hrdata, rq.pop_front());
    if (rdph && hreadyout) chk({31'h0, hresp}, 32'h0);
    if (rx_dma_done) chk({21'h0, since}, {21'h0, tq.pop_front()});
  end
  initial begin
    logic [7:0] v;
    logic [7:0] ix[8] = '{`URTI_IDX_CTRL, `URTI_IDX_FLOW, `URTI_IDX_THR, `URTI_IDX_TBASE, `URTI_IDX_TSCALE,
      `URTI_IDX_IEN, `URTI_IDX_ISTAT, 8'h9C};
    logic [7:0] rv[8] = '{8'h0F, 8'hA5, 8'h44, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] fm[6] = '{8'h00, 8'h10, 8'hE0, 8'hC0, 8'h83, 8'h93};
    logic [5:0] fe = 6'b100110;
    void'($urandom(32'hBBCC));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) xf(0, ix[k], {24'h0, rv[k]});
    repeat (3) begin
      v = 8'($urandom);
      xf(1, `URTI_IDX_THR, {24'h0, v});
      xf(0, `URTI_IDX_THR, {24'h0, v});
      xf(1, `URTI_IDX_TSCALE, {24'h0, v});
      xf(0, `URTI_IDX_TSCALE, {30'h0, v[1:0]});
      xf(1, 8'h9C, 32'hFF);
    end
    for (int k = 0; k < 6; k++) begin
      xf(1, `URTI_IDX_FLOW, {24'h0, fm[k]});
      settle();
      chk({31'h0, rts}, {31'h0, fe[k]});
    end
    xf(1, `URTI_IDX_FLOW, 32'h0);
    // Fixed thresholds so that later bursts raise no receive buffer event
    xf(1, `URTI_IDX_THR, 32'hFF);
    xf(1, `URTI_IDX_CTRL, 32'h13);
    // Base for sixteen-bit characters at three cycles a bit
    xf(1, `URTI_IDX_TBASE, 32'h30);
    chk({28'h0, bit_cycles}, 32'h3);
    chk({31'h0, rx_dma_en}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      xf(1, `URTI_IDX_TSCALE, 32'(s));
      tq.push_back(11'(48 * (s + 1)));
      send(4'h3);
      wdone();
    end
    xf(1, `URTI_IDX_ICLR, 32'h7);
    xf(1, `URTI_IDX_IEN, 32'h4);
    tq.push_back(11'h0C0);
    send(4'h2);
    wdone();
    xf(0, `URTI_IDX_ISTAT, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h1);
    xf(1, `URTI_IDX_IEN, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    xf(1, `URTI_IDX_IEN, 32'h4);
    xf(1, `URTI_IDX_ICLR, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h0);
    xf(1, `URTI_IDX_CTRL, 32'h03);
    send(4'h0);
    xf(1, `URTI_IDX_THR, 32'h25);
    xf(1, `URTI_IDX_ICLR, 32'h7);
    tx_buf_cnt <= 4'h2;
    send(4'h5);
    wcnt(4'h5);
    settle();
    xf(0, `URTI_IDX_ISTAT, 32'h3);
    xf(1, `URTI_IDX_FLOW, 32'h83);
    send(4'h6);
    wcnt(4'h3);
    repeat (61) @(posedge mclk);
    chk({28'h0, rx_buf_cnt}, 32'h3);
    chk({31'h0, rts}, 32'h1);
    send(4'h3);
    wcnt(4'h3);
    stop_test();
  end
endmodule
